// ---- rtl/fcr_channel_regs.v ----
`timescale 1ns/1ps
`include "fcr_defs.vh"
// ----------------------------------------
// per-channel shaper register pair
// ----------------------------------------
module fcr_channel_regs (
    input wire clk_in,
    input wire reset_in,
    input wire wr_ctrl_in,
    input wire wr_tune_in,
    input wire [7:0] wdata_in,
    output reg [7:0] ctrl_out,
    output reg [7:0] tune_out
);
    // reserved bits masked on write so they read zero
    always @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_out <= `FCR_RST_SHAPER_CTRL;
            tune_out <= `FCR_RST_SHAPER_TUNE;
        end else begin
            if (wr_ctrl_in) begin
                ctrl_out <= wdata_in & `FCR_MASK_SHAPER_CTRL;
            end
            if (wr_tune_in) begin
                tune_out <= wdata_in & `FCR_MASK_SHAPER_TUNE;
            end
        end
    end
endmodule

// ---- rtl/fcr_defs.vh ----
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH
// register offsets
`define FCR_ADDR_SELFTEST_LOW 8'h24
`define FCR_ADDR_SELFTEST_HIGH 8'h25
`define FCR_ADDR_SYNC_CTRL 8'h3a
`define FCR_ADDR_SHAPER_CTRL 8'h3c
`define FCR_ADDR_SHAPER_TUNE 8'h3e
// reset values
`define FCR_RST_SYNC_CTRL 8'h00
`define FCR_RST_SHAPER_CTRL 8'h00
`define FCR_RST_SHAPER_TUNE 8'h1c
// field positions
`define FCR_SYNC_MASTER_BIT 0
`define FCR_SYNC_DIVIDER_BIT 1
`define FCR_SHAPER_EN_BIT 0
`define FCR_SHAPER_MODE_LSB 1
`define FCR_SHAPER_MODE_MSB 3
`define FCR_SHAPER_PINDIS_BIT 4
// writable masks
`define FCR_MASK_SYNC_CTRL 8'h03
`define FCR_MASK_SHAPER_CTRL 8'h1f
`define FCR_MASK_SHAPER_TUNE 8'h3f
// bandwidth modes
`define FCR_MODE_NARROW 3'h0
`define FCR_MODE_WIDE 3'h1
// count of legal tuning words per mode
`define FCR_TUNE_COUNT_NARROW 6'h39
`define FCR_TUNE_COUNT_WIDE 6'h22
`endif

// ---- rtl/fcr_feature_regs.v ----
`timescale 1ns/1ps
`include "fcr_defs.vh"
// Overview of operation
// - divider sync bit gates sync pulse
// - sync active only with both bits set
// - master bit off disables all sync
// - pin-disable bit selects pin or register
// - local writes hit only indexed channels
// - mode 000 selects narrow bandwidth
// - mode 001 selects wide bandwidth
// - register enable drives shaper when selected
// - register enable ignored unless pin disabled
// - six-bit tuning word sets band edges
// - 57 narrow, 34 wide legal words
// - each step moves edge half percent
module fcr_feature_regs (
    input wire clk_in,
    input wire reset_in,
    input wire wr_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    output reg [7:0] rdata_out,
    input wire [1:0] chan_select_in,
    input wire [15:0] selftest_a_in,
    input wire [15:0] selftest_b_in,
    input wire sync_request_in,
    input wire shaper_pin_a_in,
    input wire shaper_pin_b_in,
    output reg divider_sync_pulse_out,
    output reg continuous_sync_out,
    output reg [1:0] shaper_active_out,
    output reg [1:0] shaper_wide_out,
    output reg [11:0] shaper_tune_out,
    output reg [1:0] tune_legal_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // write strobe aimed at one register offset; every register decodes
    // its own hit so an unmapped offset simply matches nothing
    function wr_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            wr_hit = strobe && (addr == target);
        end
    endfunction

    // mode field of a shaper control byte
    function [2:0] mode_of;
        input [7:0] ctrl;
        begin
            mode_of = ctrl[`FCR_SHAPER_MODE_MSB:`FCR_SHAPER_MODE_LSB];
        end
    endfunction

    // wide bandwidth only for code 001; 000 and the spare codes stay narrow
    function is_wide;
        input [7:0] ctrl;
        begin
            is_wide = (mode_of(ctrl) == `FCR_MODE_WIDE);
        end
    endfunction

    // the pin governs until pin-disable is set, then the enable bit does;
    // the enable bit is stored either way so a later switch takes it at once
    function shaper_on;
        input [7:0] ctrl;
        input pin;
        begin
            if (ctrl[`FCR_SHAPER_PINDIS_BIT]) begin
                shaper_on = ctrl[`FCR_SHAPER_EN_BIT];
            end else begin
                shaper_on = pin;
            end
        end
    endfunction

    // tuning word legal for the chosen mode; spare mode codes have none
    function tune_ok;
        input [2:0] mode;
        input [5:0] word;
        begin
            if (mode == `FCR_MODE_WIDE) begin
                tune_ok = (word < `FCR_TUNE_COUNT_WIDE);
            end else if (mode == `FCR_MODE_NARROW) begin
                tune_ok = (word < `FCR_TUNE_COUNT_NARROW);
            end else begin
                tune_ok = 1'b0;
            end
        end
    endfunction

    // local read source: channel b only when it alone is selected
    function [7:0] pick_local;
        input take_b;
        input [7:0] val_a;
        input [7:0] val_b;
        begin
            if (take_b) begin
                pick_local = val_b;
            end else begin
                pick_local = val_a;
            end
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // the sync and shaper enable pins are asynchronous to clk_in, so each passes two
    // flops before any decision; a pin change costs three cycles to show
    wire sync_req_s;
    wire pin_a_s;
    wire pin_b_s;
    fcr_sync2 u_sync_req (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(sync_request_in),
        .q_out(sync_req_s)
    );
    fcr_sync2 u_pin_a (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(shaper_pin_a_in),
        .q_out(pin_a_s)
    );
    fcr_sync2 u_pin_b (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(shaper_pin_b_in),
        .q_out(pin_b_s)
    );

    // ----------------------------------------
    // global sync control register
    // ----------------------------------------
    wire wr_sync = wr_hit(wr_en_in, addr_in, `FCR_ADDR_SYNC_CTRL);
    reg [7:0] sync_ctrl;
    reg [7:0] next_sync_ctrl;

    // only the two low bits hold data; the open bits never store anything
    always @* begin
        next_sync_ctrl = sync_ctrl;
        if (wr_sync) begin
            next_sync_ctrl = wdata_in & `FCR_MASK_SYNC_CTRL;
        end
    end

    // global register: the channel index does not gate it, and one
    // write reaches the sync logic of both channels at the same edge
    always @(posedge clk_in) begin
        if (reset_in) begin
            sync_ctrl <= `FCR_RST_SYNC_CTRL;
        end else begin
            sync_ctrl <= next_sync_ctrl;
        end
    end

    // the two sync bits
    wire master_on = sync_ctrl[`FCR_SYNC_MASTER_BIT];
    wire divider_on = sync_ctrl[`FCR_SYNC_DIVIDER_BIT];
    // with the master bit low nothing below can act, whatever the divider bit says
    wire sync_allowed = master_on & divider_on;

    // ----------------------------------------
    // divider sync outputs
    // ----------------------------------------
    reg next_divider_pulse;
    reg next_continuous;

    // the request passes only while both bits are set; clearing either bit
    // cuts the pulse on the next edge, so a half-written setup cannot fire
    always @* begin
        next_divider_pulse = sync_req_s & sync_allowed;
        next_continuous = sync_allowed;
    end

    // outputs are registered so the divider sees clean levels
    always @(posedge clk_in) begin
        if (reset_in) begin
            divider_sync_pulse_out <= 1'b0;
            continuous_sync_out <= 1'b0;
        end else begin
            divider_sync_pulse_out <= next_divider_pulse;
            continuous_sync_out <= next_continuous;
        end
    end

    // ----------------------------------------
    // local shaper registers, two channels
    // ----------------------------------------
    wire wr_ctrl = wr_hit(wr_en_in, addr_in, `FCR_ADDR_SHAPER_CTRL);
    wire wr_tune = wr_hit(wr_en_in, addr_in, `FCR_ADDR_SHAPER_TUNE);
    wire [7:0] ctrl_a;
    wire [7:0] ctrl_b;
    wire [7:0] tune_a;
    wire [7:0] tune_b;

    // writes land only on channels the index selects; with no channel
    // selected a local write is dropped without a trace
    wire wr_ctrl_a = wr_ctrl & chan_select_in[0];
    wire wr_tune_a = wr_tune & chan_select_in[0];
    wire wr_ctrl_b = wr_ctrl & chan_select_in[1];
    wire wr_tune_b = wr_tune & chan_select_in[1];

    // one register pair per channel
    fcr_channel_regs u_chan_a (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_ctrl_in(wr_ctrl_a),
        .wr_tune_in(wr_tune_a),
        .wdata_in(wdata_in),
        .ctrl_out(ctrl_a),
        .tune_out(tune_a)
    );
    fcr_channel_regs u_chan_b (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_ctrl_in(wr_ctrl_b),
        .wr_tune_in(wr_tune_b),
        .wdata_in(wdata_in),
        .ctrl_out(ctrl_b),
        .tune_out(tune_b)
    );

    // ----------------------------------------
    // shaper control outputs
    // ----------------------------------------
    // mode fields pulled out once per channel
    wire [2:0] mode_a = mode_of(ctrl_a);
    wire [2:0] mode_b = mode_of(ctrl_b);
    reg [1:0] next_active;
    reg [1:0] next_wide;
    reg [11:0] next_tune;
    reg [1:0] next_legal;

    // channel a owns bit 0 and the low tuning field, channel b bit 1 and the high field
    always @* begin
        next_active[0] = shaper_on(ctrl_a, pin_a_s);
        next_active[1] = shaper_on(ctrl_b, pin_b_s);
        next_wide[0] = is_wide(ctrl_a);
        next_wide[1] = is_wide(ctrl_b);
        // the word leaves unscaled; one lsb moves the edges half a percent of fs
        next_tune = {tune_b[5:0], tune_a[5:0]};
        // a word past the mode's count is flagged, not clipped, so software sees it
        next_legal[0] = tune_ok(mode_a, tune_a[5:0]);
        next_legal[1] = tune_ok(mode_b, tune_b[5:0]);
    end

    // registered so the downstream shaper never sees a glitch from the pins
    always @(posedge clk_in) begin
        if (reset_in) begin
            shaper_active_out <= 2'b00;
            shaper_wide_out <= 2'b00;
            shaper_tune_out <= 12'h000;
            tune_legal_out <= 2'b00;
        end else begin
            shaper_active_out <= next_active;
            shaper_wide_out <= next_wide;
            shaper_tune_out <= next_tune;
            tune_legal_out <= next_legal;
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // both channels selected reads channel a; the host sees one channel at
    // a time and must move the index to look at the other one
    wire use_b = ~chan_select_in[0] & chan_select_in[1];
    reg [7:0] next_rdata;

    // selftest words have no write path at all, so they stay read only
    always @* begin
        case (addr_in)
            `FCR_ADDR_SELFTEST_LOW: begin
                next_rdata = pick_local(use_b, selftest_a_in[7:0], selftest_b_in[7:0]);
            end
            `FCR_ADDR_SELFTEST_HIGH: begin
                next_rdata = pick_local(use_b, selftest_a_in[15:8], selftest_b_in[15:8]);
            end
            `FCR_ADDR_SYNC_CTRL: begin
                next_rdata = sync_ctrl;
            end
            `FCR_ADDR_SHAPER_CTRL: begin
                next_rdata = pick_local(use_b, ctrl_a, ctrl_b);
            end
            `FCR_ADDR_SHAPER_TUNE: begin
                next_rdata = pick_local(use_b, tune_a, tune_b);
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data is a flop, so it answers one cycle after the address
    always @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end
endmodule

// ---- rtl/fcr_sync2.v ----
`timescale 1ns/1ps
// ----------------------------------------
// two-flop synchroniser for pins
// ----------------------------------------
module fcr_sync2 (
    input wire clk_in,
    input wire reset_in,
    input wire d_in,
    output reg q_out
);
    reg stage1;
    // first stage is read only by the second
    always @(posedge clk_in) begin
        if (reset_in) begin
            stage1 <= 1'b0;
            q_out <= 1'b0;
        end else begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule

// ---- verification/fcr_feature_regs_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// register slice checker
// ----------------------------------------
module fcr_feature_regs_assertions (
    input wire clk_in,
    input wire reset_in,
    input wire wr_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rdata_out,
    input wire [1:0] chan_select_in,
    input wire [15:0] selftest_a_in,
    input wire [15:0] selftest_b_in,
    input wire divider_sync_pulse_out,
    input wire continuous_sync_out
);
    reg [1:0] sync_q;
    // shadow of the sync bits, so outputs can be tied back to what was written
    always @(posedge clk_in) begin
        if (reset_in)
            sync_q <= 2'h0;
        else if (wr_en_in && addr_in == 8'h3a)
            sync_q <= wdata_in[1:0];
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // past reset guards keep reset-time values out of the comparisons
    a_sync_both_set: assert property (!$past(reset_in) |-> continuous_sync_out == $past(sync_q == 2'h3))
        else $error("continuous sync does not follow both sync bits");
    a_divider_gate_on: assert property (divider_sync_pulse_out |-> $past(sync_q[1]))
        else $error("sync pulse passed with divider bit low");
    a_master_off_all: assert property (!$past(reset_in) && !$past(sync_q[0]) |->
        !divider_sync_pulse_out && !continuous_sync_out)
        else $error("sync active with master bit low");
    a_sync_read_back: assert property (!$past(reset_in) && $past(addr_in) == 8'h3a |->
        rdata_out == {6'h00, $past(sync_q)})
        else $error("sync register read back wrong");
    a_selftest_low_read: assert property (!$past(reset_in) && $past(addr_in) == 8'h24 |->
        rdata_out == (($past(chan_select_in) == 2'h2) ? $past(selftest_b_in[7:0]) : $past(selftest_a_in[7:0])))
        else $error("selftest low byte wrong");
    a_ctrl_reserved_zero: assert property ($past(addr_in) == 8'h3c |-> rdata_out[7:5] == 3'h0)
        else $error("shaper control reserved bits set");
    a_tune_reserved_zero: assert property ($past(addr_in) == 8'h3e |-> rdata_out[7:6] == 2'h0)
        else $error("tuning reserved bits set");
    a_unmapped_reads_zero: assert property ($past(addr_in) == 8'h30 |-> rdata_out == 8'h00)
        else $error("unmapped address read nonzero");
endmodule

bind fcr_feature_regs fcr_feature_regs_assertions i_chk (.clk_in(clk_in), .reset_in(reset_in), .wr_en_in(wr_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .chan_select_in(chan_select_in),
    .selftest_a_in(selftest_a_in), .selftest_b_in(selftest_b_in),
    .divider_sync_pulse_out(divider_sync_pulse_out), .continuous_sync_out(continuous_sync_out));

// ---- verification/fcr_testbench.sv ----
`timescale 1ns/1ps
module testbench;
    reg clk_in = 0, reset_in = 1, wr_en_in = 0, sync_request_in = 0, shaper_pin_a_in = 0, shaper_pin_b_in = 0;
    reg [7:0] addr_in = 8'h00, wdata_in = 8'h00;
    reg [1:0] chan_select_in = 2'h0;
    reg [15:0] selftest_a_in = 16'hb4c7, selftest_b_in = 16'h5a39;
    wire [7:0] rdata_out;
    wire divider_sync_pulse_out, continuous_sync_out;
    wire [1:0] shaper_active_out, shaper_wide_out, tune_legal_out;
    wire [11:0] shaper_tune_out;
    integer bad_count = 0, checked = 0, w;
    always #4 clk_in = ~clk_in;
    fcr_feature_regs i_dut (.clk_in(clk_in), .reset_in(reset_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .rdata_out(rdata_out), .chan_select_in(chan_select_in), .selftest_a_in(selftest_a_in),
        .selftest_b_in(selftest_b_in), .sync_request_in(sync_request_in), .shaper_pin_a_in(shaper_pin_a_in),
        .shaper_pin_b_in(shaper_pin_b_in), .divider_sync_pulse_out(divider_sync_pulse_out),
        .continuous_sync_out(continuous_sync_out), .shaper_active_out(shaper_active_out),
        .shaper_wide_out(shaper_wide_out), .shaper_tune_out(shaper_tune_out), .tune_legal_out(tune_legal_out));
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task chk(input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // inputs always move 1 ns after an edge, away from sampling
    task cyc(input integer n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one-cycle write strobe, then one edge for the derived outputs
    task wr(input [7:0] a, input [7:0] d);
        wr_en_in = 1;
        addr_in = a;
        wdata_in = d;
        cyc(1);
        wr_en_in = 0;
        cyc(1);
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        addr_in = a;
        cyc(1);
        chk(rdata_out, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rd(8'h3a, 8'h00);
        rd(8'h3c, 8'h00);
        rd(8'h3e, 8'h1c);
        chk(shaper_tune_out, 12'h71c);
        chk(tune_legal_out, 2'h3);
        $display("reset test done");
    endtask
    task t_sync;
        sync_request_in = 1;
        wr(8'h3a, 8'h01);
        cyc(3);
        chk({divider_sync_pulse_out, continuous_sync_out}, 2'h0);
        wr(8'h3a, 8'h02);
        chk({divider_sync_pulse_out, continuous_sync_out}, 2'h0);
        wr(8'h3a, 8'hff);
        chk({divider_sync_pulse_out, continuous_sync_out}, 2'h3);
        rd(8'h3a, 8'h03);
        sync_request_in = 0;
        cyc(3);
        chk({divider_sync_pulse_out, continuous_sync_out}, 2'h1);
        wr(8'h3a, 8'h00);
        chk({divider_sync_pulse_out, continuous_sync_out}, 2'h0);
        $display("sync test done");
    endtask
    task t_shaper;
        shaper_pin_b_in = 1;
        chan_select_in = 2'h1;
        wr(8'h3c, 8'h13);
        cyc(2);
        chk(shaper_active_out, 2'h3);
        chk(shaper_wide_out, 2'h1);
        chan_select_in = 2'h2;
        wr(8'h3c, 8'h10);
        chk(shaper_active_out, 2'h1);
        chk(shaper_wide_out, 2'h1);
        chan_select_in = 2'h0;
        wr(8'h3c, 8'h00);
        chk(shaper_active_out, 2'h1);
        chan_select_in = 2'h1;
        wr(8'h3c, 8'h03);
        chk(shaper_active_out, 2'h0);
        shaper_pin_a_in = 1;
        cyc(3);
        chk(shaper_active_out, 2'h1);
        rd(8'h3c, 8'h03);
        $display("shaper test done");
    endtask
    task t_tune;
        chan_select_in = 2'h3;
        for (w = 33; w < 58; w = w + 1) begin
            wr(8'h3e, w[7:0]);
            chk(tune_legal_out, {w < 57, w < 34});
            chk(shaper_tune_out, {w[5:0], w[5:0]});
        end
        wr(8'h3e, 8'hff);
        rd(8'h3e, 8'h3f);
        chk(shaper_tune_out, 12'hfff);
        chan_select_in = 2'h2;
        wr(8'h24, 8'hff);
        rd(8'h24, 8'h39);
        rd(8'h25, 8'h5a);
        rd(8'h30, 8'h00);
        chan_select_in = 2'h3;
        wr(8'h3e, 8'h05);
        chan_select_in = 2'h1;
        wr(8'h3c, 8'h15);
        chk(tune_legal_out, 2'h2);
        chk(shaper_wide_out, 2'h0);
        $display("tuning and read-only test done");
    endtask
    task wrap_up;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence, reset held for five edges
    initial begin
        cyc(5);
        reset_in = 0;
        t_reset;
        t_sync;
        t_shaper;
        t_tune;
        wrap_up;
    end
    // watchdog in case the run hangs
    initial begin
        #100000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule
